/* hw/bobse_pkg.sv */
// Shared types, encodings, register map and helpers of the execute slice.
package bobse_pkg;

   typedef enum logic [1:0] {
      PH_DECODE = 2'b00,
      PH_READ = 2'b01,
      PH_PROC = 2'b10,
      PH_WRITE = 2'b11
   } bobse_phase_t;

   typedef enum logic [2:0] {
      OP_NOP = 3'b000,
      OP_AND = 3'b001,
      OP_BRC = 3'b010,
      OP_CLR_FILE = 3'b011,
      OP_CLR_WDOG = 3'b100,
      OP_INCSZ = 3'b101,
      OP_INSNZ = 3'b110
   } bobse_op_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic re;
      logic we;
   } bobse_rf_req_t;

   typedef struct packed {
      logic [7:0] result;
      logic neg;
      logic zero;
      logic skip;
   } bobse_alu_t;

   // Opcode patterns, compared against the top bits of the word.
   localparam logic [5:0] ENC_AND = 6'h05;
   localparam logic [7:0] ENC_BRC = 8'hE2;
   localparam logic [6:0] ENC_CLR_FILE = 7'h35;
   localparam logic [15:0] ENC_CLR_WDOG = 16'h0004;
   localparam logic [5:0] ENC_INCSZ = 6'h0F;
   localparam logic [5:0] ENC_INSNZ = 6'h12;
   localparam logic [3:0] ENC_2W_MOVE = 4'hC;
   localparam logic [5:0] ENC_2W_CTRL = 6'h3B;
   localparam logic [15:0] NOP_WORD = 16'h0000;

   localparam int D_BIT = 9;
   localparam int A_BIT = 8;
   localparam int ACCESS_SPLIT = 7;
   localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hF;

   localparam int ST_C = 0;
   localparam int ST_Z = 1;
   localparam int ST_N = 2;
   localparam int ST_SLEEP = 3;
   localparam int ST_TO = 4;
   localparam logic [4:0] STAT_RST = 5'h18;

   localparam logic [20:0] PC_RST = 21'h00_0000;
   localparam logic [20:0] PC_STEP = 21'h00_0002;
   localparam logic [1:0] SKIP_ONE = 2'h1;
   localparam logic [1:0] SKIP_TWO = 2'h2;

   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ACCUM = 8'h04;
   localparam logic [7:0] REG_BANK = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_PC = 8'h10;
   localparam logic [7:0] REG_IR = 8'h14;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   function automatic bobse_op_t decode_op(input logic [15:0] w);
      if (w[15:10] == ENC_AND) return OP_AND;
      if (w[15:8] == ENC_BRC) return OP_BRC;
      if (w[15:9] == ENC_CLR_FILE) return OP_CLR_FILE;
      if (w == ENC_CLR_WDOG) return OP_CLR_WDOG;
      if (w[15:10] == ENC_INCSZ) return OP_INCSZ;
      if (w[15:10] == ENC_INSNZ) return OP_INSNZ;
      return OP_NOP;
   endfunction : decode_op

   function automatic logic is_two_word(input logic [15:0] w);
      return (w[15:12] == ENC_2W_MOVE) || (w[15:10] == ENC_2W_CTRL);
   endfunction : is_two_word

   function automatic logic [11:0] file_addr(input logic [7:0] f,
                                             input logic a,
                                             input logic [3:0] bank);
      if (a) return {bank, f};
      return {f[ACCESS_SPLIT] ? ACCESS_HI_BANK : ACCESS_LO_BANK, f};
   endfunction : file_addr

endpackage : bobse_pkg

/* hw/bobse_qdiv.sv */
// Four-phase sequencer that splits each instruction cycle.
`timescale 1ns/1ps
module bobse_qdiv
   import bobse_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic run,
   output logic step,
   output bobse_phase_t phase
);

   bobse_phase_t phase_ff;
   bobse_phase_t nxt_phase;

   // A started cycle always runs to its write phase before halting.
   assign step = run || (phase_ff != PH_DECODE);
   assign phase = phase_ff;

   always_comb begin
      nxt_phase = phase_ff;
      if (step) begin
         unique case (phase_ff)
            PH_DECODE: nxt_phase = PH_READ;
            PH_READ: nxt_phase = PH_PROC;
            PH_PROC: nxt_phase = PH_WRITE;
            PH_WRITE: nxt_phase = PH_DECODE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         phase_ff <= PH_DECODE;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

endmodule : bobse_qdiv

/* hw/bobse_alu.sv */
// Data path for the and and increment operations; any other op gives zero.
`timescale 1ns/1ps
module bobse_alu
   import bobse_pkg::*;
(
   input wire bobse_op_t op,
   input wire logic [7:0] accum,
   input wire logic [7:0] operand,
   output bobse_alu_t res
);

   always_comb begin
      res = '0;
      unique case (op)
         OP_AND: res.result = accum & operand;
         OP_INCSZ, OP_INSNZ: res.result = operand + 8'h01;
         default: res.result = 8'h00;
      endcase
      res.neg = res.result[7];
      res.zero = (res.result == 8'h00);
      res.skip = (op == OP_INCSZ && res.zero) ||
                 (op == OP_INSNZ && !res.zero);
   end

endmodule : bobse_alu

/* hw/bobse_core.sv */
// Execute slice for six byte, branch and skip instructions, AXI4-Lite regs.
// Function
// [RULE1] And accumulator with file register; result to destination; set N, Z.
// [RULE2] Destination bit 0 sends result to accumulator, 1 to file register.
// [RULE3] Bank bit 0 forces access bank; 1 uses bank pointer.
// [RULE4] Branch on carry adds twice signed offset; two cycles taken, one not.
// [RULE5] Clear file register writes zero and sets the zero flag.
// [RULE6] Clear watchdog resets counter and postscaler, sets expiry, sleep flags.
// [RULE7] Increment, skip fetched instruction when result is zero; flags kept.
// [RULE8] Increment, skip fetched instruction when result is nonzero; flags kept.
// [RULE9] Skip costs one extra cycle, two when skipped word pair is long.
// [RULE10] Each cycle runs decode, read, process, write phases in order.
`timescale 1ns/1ps
module bobse_core
   import bobse_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [20:0] pm_addr,
   input wire logic [15:0] pm_data,
   output bobse_rf_req_t rf_req,
   input wire logic [7:0] rf_rdata,
   output logic watchdog_clr
);

   function automatic logic reg_mapped(input logic [7:0] a);
      return a == REG_CTRL || a == REG_ACCUM || a == REG_BANK ||
             a == REG_STATUS || a == REG_PC || a == REG_IR;
   endfunction : reg_mapped

   ////////////////////////////////////////////////////////////////////////
   // Bus slave state.
   logic aw_ff, nxt_aw, w_ff, nxt_w;
   logic [7:0] awaddr_ff, nxt_awaddr;
   logic [31:0] wdata_ff, nxt_wdata;
   logic [3:0] wstrb_ff, nxt_wstrb;
   logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
   logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic [31:0] rdata_ff, nxt_rdata, rd_word;
   logic bus_wr;

   ////////////////////////////////////////////////////////////////////////
   // Core state.
   logic run_ff, nxt_run;
   logic [7:0] accum_ff, nxt_accum;
   logic [3:0] bank_ff, nxt_bank;
   logic [4:0] stat_ff, nxt_stat;
   logic [20:0] pc_ff, nxt_pc;
   logic [15:0] ir_ff, nxt_ir;
   bobse_op_t op_ff, nxt_op;
   logic [1:0] skip_ff, nxt_skip;
   bobse_alu_t alu_ff, nxt_alu, alu_out;
   bobse_rf_req_t req_ff, nxt_req;
   logic wdog_clr_ff, nxt_wdog_clr;
   logic step;
   bobse_phase_t phase;

   bobse_qdiv u_qdiv (
      .clock(clock),
      .sys_rst(sys_rst),
      .run(run_ff),
      .step(step),
      .phase(phase)
   );

   bobse_alu u_alu (
      .op(op_ff),
      .accum(accum_ff),
      .operand(rf_rdata),
      .res(alu_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave; address and data may arrive in either order.
   assign s_axi_awready = !aw_ff && !bvalid_ff;
   assign s_axi_wready = !w_ff && !bvalid_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rdata = rdata_ff;
   assign bus_wr = aw_ff && w_ff && !bvalid_ff;

   always_comb begin
      unique case (s_axi_araddr)
         REG_CTRL: rd_word = {31'h0000_0000, run_ff};
         REG_ACCUM: rd_word = {24'h00_0000, accum_ff};
         REG_BANK: rd_word = {28'h000_0000, bank_ff};
         REG_STATUS: rd_word = {27'h000_0000, stat_ff};
         REG_PC: rd_word = {11'h000, pc_ff};
         REG_IR: rd_word = {16'h0000, ir_ff};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_comb begin
      nxt_aw = aw_ff;
      nxt_awaddr = awaddr_ff;
      nxt_w = w_ff;
      nxt_wdata = wdata_ff;
      nxt_wstrb = wstrb_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_aw = 1'b1;
         nxt_awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_w = 1'b1;
         nxt_wdata = s_axi_wdata;
         nxt_wstrb = s_axi_wstrb;
      end
      if (bus_wr) begin
         nxt_aw = 1'b0;
         nxt_w = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = reg_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_rvalid = 1'b1;
         nxt_rdata = rd_word;
         nxt_rresp = reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         aw_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         w_ff <= 1'b0;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_OKAY;
      end else begin
         aw_ff <= nxt_aw;
         awaddr_ff <= nxt_awaddr;
         w_ff <= nxt_w;
         wdata_ff <= nxt_wdata;
         wstrb_ff <= nxt_wstrb;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Instruction execution; hardware updates win over a same-cycle write.
   assign pm_addr = pc_ff;
   assign rf_req = req_ff;
   assign watchdog_clr = wdog_clr_ff;

   always_comb begin
      nxt_run = run_ff;
      nxt_accum = accum_ff;
      nxt_bank = bank_ff;
      nxt_stat = stat_ff;
      nxt_pc = pc_ff;
      nxt_ir = ir_ff;
      nxt_op = op_ff;
      nxt_skip = skip_ff;
      nxt_alu = alu_ff;
      nxt_req = req_ff;
      nxt_req.re = 1'b0;
      nxt_req.we = 1'b0;
      nxt_wdog_clr = 1'b0;
      if (bus_wr && wstrb_ff[0]) begin
         unique case (awaddr_ff)
            REG_CTRL: nxt_run = wdata_ff[0];
            REG_ACCUM: nxt_accum = wdata_ff[7:0];
            REG_BANK: nxt_bank = wdata_ff[3:0];
            REG_STATUS: nxt_stat = wdata_ff[4:0];
            default: ;
         endcase
      end
      if (step) begin
         unique case (phase) // see [RULE10]
            PH_DECODE: begin
               if (skip_ff != 2'h0) begin
                  nxt_op = OP_NOP; // see [RULE7] see [RULE8] see [RULE9]
                  nxt_skip = skip_ff - SKIP_ONE;
               end else begin
                  nxt_op = decode_op(ir_ff);
               end
            end
            PH_READ: begin
               if (op_ff == OP_AND || op_ff == OP_CLR_FILE ||
                   op_ff == OP_INCSZ || op_ff == OP_INSNZ) begin
                  nxt_req.re = 1'b1;
                  nxt_req.addr = file_addr(ir_ff[7:0], ir_ff[A_BIT],
                                           bank_ff); // see [RULE3]
               end
            end
            PH_PROC: nxt_alu = alu_out; // see [RULE1]
            PH_WRITE: begin
               nxt_ir = pm_data;
               nxt_pc = pc_ff + PC_STEP;
               unique case (op_ff)
                  OP_AND, OP_INCSZ, OP_INSNZ: begin
                     if (ir_ff[D_BIT]) begin // see [RULE2]
                        nxt_req.we = 1'b1;
                        nxt_req.wdata = alu_ff.result;
                     end else begin
                        nxt_accum = alu_ff.result;
                     end
                     if (op_ff == OP_AND) begin
                        nxt_stat[ST_N] = alu_ff.neg; // see [RULE1]
                        nxt_stat[ST_Z] = alu_ff.zero;
                     end else if (alu_ff.skip) begin
                        // The word just fetched is dropped; a long one
                        // drops its second word too.
                        nxt_skip = is_two_word(pm_data) ? SKIP_TWO
                                                        : SKIP_ONE; // see [RULE9]
                     end
                  end
                  OP_CLR_FILE: begin
                     nxt_req.we = 1'b1; // see [RULE5]
                     nxt_req.wdata = 8'h00;
                     nxt_stat[ST_Z] = 1'b1;
                  end
                  OP_CLR_WDOG: begin
                     nxt_wdog_clr = 1'b1; // see [RULE6]
                     nxt_stat[ST_TO] = 1'b1;
                     nxt_stat[ST_SLEEP] = 1'b1;
                  end
                  OP_BRC: begin
                     if (stat_ff[ST_C]) begin // see [RULE4]
                        nxt_pc = pc_ff + {{12{ir_ff[7]}}, ir_ff[7:0], 1'b0};
                        nxt_ir = NOP_WORD;
                     end
                  end
                  default: ;
               endcase
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         run_ff <= 1'b0;
         accum_ff <= 8'h00;
         bank_ff <= 4'h0;
         stat_ff <= STAT_RST;
         pc_ff <= PC_RST;
         ir_ff <= NOP_WORD;
         op_ff <= OP_NOP;
         skip_ff <= 2'h0;
         alu_ff <= '0;
         req_ff <= '0;
         wdog_clr_ff <= 1'b0;
      end else begin
         run_ff <= nxt_run;
         accum_ff <= nxt_accum;
         bank_ff <= nxt_bank;
         stat_ff <= nxt_stat;
         pc_ff <= nxt_pc;
         ir_ff <= nxt_ir;
         op_ff <= nxt_op;
         skip_ff <= nxt_skip;
         alu_ff <= nxt_alu;
         req_ff <= nxt_req;
         wdog_clr_ff <= nxt_wdog_clr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   logic wr_ph;
   logic next_long;
   assign wr_ph = step && phase == PH_WRITE;
   assign next_long = is_two_word(pm_data);

   sequence read_then_proc;
      phase == PH_PROC ##1 phase == PH_WRITE;
   endsequence

   sequence skip_start;
      wr_ph && (op_ff == OP_INCSZ || op_ff == OP_INSNZ) && alu_ff.skip;
   endsequence

   and_result_a: assert property ( // see [RULE1]
      step && phase == PH_PROC && op_ff == OP_AND |=>
      (alu_ff.result == ($past(accum_ff) & $past(rf_rdata))) ##1
      (stat_ff[ST_Z] == (alu_ff.result == 8'h00)))
      else $error("and result or flags wrong");

   dest_select_a: assert property ( // see [RULE2]
      wr_ph && op_ff == OP_AND |=>
      (req_ff.we == $past(ir_ff[D_BIT])) &&
      ($past(ir_ff[D_BIT]) || accum_ff == $past(alu_ff.result)))
      else $error("result sent to wrong destination");

   bank_select_a: assert property ( // see [RULE3]
      step && phase == PH_READ && op_ff == OP_CLR_FILE && !ir_ff[A_BIT] |=>
      req_ff.re && req_ff.addr[11:8] ==
      ($past(ir_ff[7]) ? ACCESS_HI_BANK : ACCESS_LO_BANK))
      else $error("access bank not forced");

   branch_taken_a: assert property ( // see [RULE4]
      wr_ph && op_ff == OP_BRC && stat_ff[ST_C] |=>
      pc_ff == $past(pc_ff) + {{12{$past(ir_ff[7])}}, $past(ir_ff[7:0]),
                               1'b0} && ir_ff == NOP_WORD)
      else $error("branch target wrong");

   clear_file_a: assert property ( // see [RULE5]
      wr_ph && op_ff == OP_CLR_FILE |=>
      req_ff.we && req_ff.wdata == 8'h00 && stat_ff[ST_Z])
      else $error("clear did not write zero");

   clear_watch_a: assert property ( // see [RULE6]
      wr_ph && op_ff == OP_CLR_WDOG |=>
      wdog_clr_ff && stat_ff[ST_TO] && stat_ff[ST_SLEEP] ##1 !wdog_clr_ff)
      else $error("watchdog clear missing");

   skip_zero_a: assert property ( // see [RULE7]
      wr_ph && op_ff == OP_INCSZ |=>
      (skip_ff != 2'h0) == ($past(alu_ff.result) == 8'h00) &&
      stat_ff == $past(stat_ff))
      else $error("skip on zero wrong");

   skip_nonzero_a: assert property ( // see [RULE8]
      wr_ph && op_ff == OP_INSNZ |=>
      (skip_ff != 2'h0) == ($past(alu_ff.result) != 8'h00))
      else $error("skip on nonzero wrong");

   skip_length_a: assert property ( // see [RULE9]
      skip_start |=> skip_ff == ($past(next_long) ? SKIP_TWO : SKIP_ONE))
      else $error("skip length wrong");

   skip_nop_a: assert property ( // see [RULE9]
      step && phase == PH_DECODE && skip_ff != 2'h0 |=>
      op_ff == OP_NOP && skip_ff == $past(skip_ff) - SKIP_ONE)
      else $error("skipped word executed");

   phase_order_a: assert property ( // see [RULE10]
      phase == PH_READ |=> read_then_proc ##1 phase == PH_DECODE)
      else $error("phase order broken");

endmodule : bobse_core

/* tb/bobse_mem_model.sv */
// Behavioural program memory and file register array facing the slice.
`timescale 1ns/1ps
module bobse_mem_model
   import bobse_pkg::*;
(
   input wire logic clock,
   input wire logic [20:0] pm_addr,
   output logic [15:0] pm_data,
   input wire bobse_rf_req_t rf_req,
   output logic [7:0] rf_rdata
);
   logic [15:0] prog [0:255];
   logic [7:0] fr [0:4095];

   initial begin
      foreach (fr[i]) begin
         fr[i] = 8'h00;
      end
   end

   // Words are fetched by byte address, so the lowest bit is dropped.
   assign pm_data = prog[pm_addr[8:1]];
   // Read data stands only while the read strobe does, and shows the
   // inverse otherwise, so a core that samples it late sees garbage.
   assign rf_rdata = (rf_req.re === 1'b1) ? fr[rf_req.addr]
                                          : ~fr[rf_req.addr];

   always @(posedge clock) begin
      if (rf_req.we === 1'b1) begin
         fr[rf_req.addr] <= rf_req.wdata;
      end
   end
endmodule : bobse_mem_model

/* tb/byte_op_branch_skip_exec_bench.sv */
// Self-checking bench for the execute slice and its memory model.
`timescale 1ns/1ps
module byte_op_branch_skip_exec_bench
   import bobse_pkg::*;
;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic [20:0] pm_addr;
   logic [15:0] pm_data;
   bobse_rf_req_t rf_req;
   logic [7:0] rf_rdata;
   logic watchdog_clr;
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int wc = 0;
   int lt[$];
   int et[$];
   logic [19:0] lv[$];
   logic [19:0] ev[$];
   logic [15:0] pq[$];

   always #25 clock = ~clock;

   bobse_core u_dut (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pm_addr, .pm_data,
      .rf_req, .rf_rdata, .watchdog_clr);
   bobse_mem_model u_pm (.clock, .pm_addr, .pm_data, .rf_req, .rf_rdata);

   // Logs every file write with its cycle, and counts watchdog pulses.
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (rf_req.we === 1'b1) begin
         lt.push_back(cyc);
         lv.push_back({rf_req.addr, rf_req.wdata});
      end
      if (watchdog_clr === 1'b1) begin
         wc++;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      if (num_errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   task automatic chk_log;
      chk(32'(lv.size()), 32'(ev.size()));
      for (int i = 0; i < ev.size() && i < lv.size(); i++) begin
         chk({12'h000, lv[i]}, {12'h000, ev[i]});
         chk(32'(lt[i] - lt[0]), 32'(et[i]));
      end
   endtask : chk_log

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] r);
      logic pa;
      logic pw;
      logic ta;
      logic tw;
      logic tb;
      logic [1:0] rs;
      int n;
      pa = 1'b1;
      pw = 1'b1;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge clock);
         ta = pa && s_axi_awready === 1'b1;
         tw = pw && s_axi_wready === 1'b1;
         tb = s_axi_bvalid === 1'b1;
         rs = s_axi_bresp;
         @(posedge clock);
         if (ta) begin
            pa = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (tw) begin
            pw = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
         n++;
      end while (!tb && n < 100);
      chk({31'h0000_0000, tb}, 32'h0000_0001);
      s_axi_bready <= 1'b0;
      @(posedge clock);
      chk({30'h0000_0000, rs}, {30'h0000_0000, r});
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                         input logic [1:0] r);
      logic pa;
      logic ta;
      logic tb;
      logic [31:0] d;
      logic [1:0] rs;
      int n;
      pa = 1'b1;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge clock);
         ta = pa && s_axi_arready === 1'b1;
         tb = s_axi_rvalid === 1'b1;
         d = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge clock);
         if (ta) begin
            pa = 1'b0;
            s_axi_arvalid <= 1'b0;
         end
         n++;
      end while (!tb && n < 100);
      chk({31'h0000_0000, tb}, 32'h0000_0001);
      s_axi_rready <= 1'b0;
      @(posedge clock);
      chk(d, e);
      chk({30'h0000_0000, rs}, {30'h0000_0000, r});
   endtask : axi_rd

   task automatic rst;
      sys_rst <= 1'b1;
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
   endtask : rst

   // Loads the program, presets registers, runs the core, then halts it.
   task automatic go(input logic [7:0] acc, input logic [7:0] bk,
                     input logic [7:0] st);
      rst();
      foreach (u_pm.prog[i]) begin
         u_pm.prog[i] = (i < pq.size()) ? pq[i] : NOP_WORD;
      end
      lt.delete();
      lv.delete();
      wc = 0;
      axi_wr(REG_ACCUM, {24'h00_0000, acc}, RESP_OKAY);
      axi_wr(REG_BANK, {24'h00_0000, bk}, RESP_OKAY);
      axi_wr(REG_STATUS, {24'h00_0000, st}, RESP_OKAY);
      axi_wr(REG_CTRL, 32'h0000_0001, RESP_OKAY);
      repeat (120) @(posedge clock);
      axi_wr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
      repeat (8) @(posedge clock);
   endtask : go

   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rst();
      axi_rd(REG_CTRL, 32'h0000_0000, RESP_OKAY);
      axi_rd(REG_ACCUM, 32'h0000_0000, RESP_OKAY);
      axi_rd(REG_STATUS, 32'h0000_0018, RESP_OKAY);
      axi_rd(REG_IR, 32'h0000_0000, RESP_OKAY);
      axi_wr(REG_PC, 32'h0000_0040, RESP_OKAY);
      axi_rd(REG_PC, 32'h0000_0000, RESP_OKAY);
      axi_wr(8'h18, 32'h0000_0001, RESP_SLVERR);
      axi_rd(8'h18, 32'h0000_0000, RESP_SLVERR);
      axi_wr(REG_BANK, 32'h0000_000A, RESP_OKAY);
      axi_rd(REG_BANK, 32'h0000_000A, RESP_OKAY);
   endtask : t_regs

   task automatic t_and;
      pq = '{16'h1420, 16'h1740, 16'h16A0, 16'hE2FF};
      u_pm.fr[12'h020] = 8'hC2;
      u_pm.fr[12'h340] = 8'h80;
      u_pm.fr[12'hFA0] = 8'h01;
      go(8'h97, 8'h03, 8'h19);
      axi_rd(REG_ACCUM, 32'h0000_0082, RESP_OKAY);
      axi_rd(REG_STATUS, 32'h0000_001B, RESP_OKAY);
      ev = '{{12'h340, 8'h80}, {12'hFA0, 8'h00}};
      et = '{0, 4};
      chk_log();
   endtask : t_and

   task automatic t_clr;
      pq = '{16'h6A30, 16'h6B12, 16'h0004, 16'hE2FF};
      u_pm.fr[12'h030] = 8'h55;
      u_pm.fr[12'h512] = 8'h66;
      go(8'h00, 8'h05, 8'h01);
      axi_rd(REG_STATUS, 32'h0000_001B, RESP_OKAY);
      chk(32'(wc), 32'h0000_0001);
      ev = '{{12'h030, 8'h00}, {12'h512, 8'h00}};
      et = '{0, 4};
      chk_log();
   endtask : t_clr

   task automatic t_skz;
      pq = '{16'h3E10, 16'h6A11, 16'h6A12, 16'h3C13, 16'h6A14, 16'h3E15,
             16'hC123, 16'hF456, 16'h6A17, 16'hE2FF};
      u_pm.fr[12'h010] = 8'hFF;
      u_pm.fr[12'h013] = 8'h05;
      u_pm.fr[12'h015] = 8'hFF;
      go(8'h00, 8'h00, 8'h05);
      axi_rd(REG_ACCUM, 32'h0000_0006, RESP_OKAY);
      axi_rd(REG_STATUS, 32'h0000_0007, RESP_OKAY);
      ev = '{{12'h010, 8'h00}, {12'h012, 8'h00}, {12'h014, 8'h00},
             {12'h015, 8'h00}, {12'h017, 8'h00}};
      et = '{0, 8, 16, 20, 32};
      chk_log();
   endtask : t_skz

   task automatic t_sknz;
      pq = '{16'h4A20, 16'h6A21, 16'h4A22, 16'h6A23, 16'h4924, 16'h6A25,
             16'hE2FF};
      u_pm.fr[12'h020] = 8'h41;
      u_pm.fr[12'h022] = 8'hFF;
      u_pm.fr[12'h224] = 8'h7F;
      go(8'h00, 8'h02, 8'h01);
      axi_rd(REG_ACCUM, 32'h0000_0080, RESP_OKAY);
      axi_rd(REG_STATUS, 32'h0000_0003, RESP_OKAY);
      ev = '{{12'h020, 8'h42}, {12'h022, 8'h00}, {12'h023, 8'h00}};
      et = '{0, 8, 12};
      chk_log();
   endtask : t_sknz

   task automatic t_bc(input logic c);
      pq = '{16'h6A32, 16'hE202, 16'h6A30, 16'h6A31, 16'h6A34, 16'hE2FF};
      go(8'h00, 8'h00, {7'h00, c});
      axi_rd(REG_STATUS, {30'h0000_0000, 1'b1, c}, RESP_OKAY);
      if (c) begin
         ev = '{{12'h032, 8'h00}, {12'h034, 8'h00}};
         et = '{0, 12};
      end else begin
         ev = '{{12'h032, 8'h00}, {12'h030, 8'h00}, {12'h031, 8'h00},
                {12'h034, 8'h00}};
         et = '{0, 8, 12, 16};
      end
      chk_log();
   endtask : t_bc

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      test_done();
   end

   initial begin
      t_regs();
      t_and();
      t_clr();
      t_skz();
      t_sknz();
      t_bc(1'b0);
      t_bc(1'b1);
      test_done();
   end
endmodule : byte_op_branch_skip_exec_bench
